// File: design/serial_port_a_pkg.sv
// How it works
// RULE1 - one or two stop bits per frame
// RULE2 - seven or eight data bits per frame
// RULE3 - msb or lsb first, same both ways
// RULE4 - parity on or off, even or odd
// RULE5 - synchronous or asynchronous mode select
// RULE6 - each send request transmits one byte; a transmit data write while the transmitter is busy is dropped
// RULE7 - transmit buffer busy and empty readable
// RULE8 - transmit interrupt enable gates the request
// RULE9 - transmit interrupt enable reads back
// RULE10 - software can set transmit flag
// RULE11 - software can clear transmit flag
// RULE12 - transmit flag pending state readable
// RULE13 - receive interrupt enable reads back
// RULE14 - baud rate changeable at any time
package serial_port_a_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned BAUD_DEFAULT = 115_200;
	localparam int unsigned DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'(CLK_HZ / BAUD_DEFAULT);

	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_BAUD = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_TXDATA = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_SET = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_TX = 0;
	localparam int unsigned IRQ_RX = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_EMPTY = 1;

	localparam int unsigned FRAME_W = 12;
	localparam int unsigned LEN_W = 4;
	localparam int unsigned CTRL_W = 6;

	// bit 0 is two_stop, bit 5 is sync_mode
	typedef struct packed {
		logic sync_mode;
		logic odd_parity;
		logic parity_on;
		logic msb_first;
		logic seven_bit;
		logic two_stop;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 6'h00;

	typedef struct packed {
		logic [FRAME_W-1:0] bits;
		logic [LEN_W-1:0] len;
	} frame_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_t;

endpackage

// File: design/serial_port_a.sv
`timescale 1ns/10ps
module serial_port_a #(
	parameter logic [serial_port_a_pkg::DIV_W-1:0] RESET_DIV = serial_port_a_pkg::DIV_RESET
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [serial_port_a_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [serial_port_a_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial line
	output logic txd,
	output logic sclk,
	// interrupt
	output logic irq
);
	import serial_port_a_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
		return a[ADDR_W-1:2] == o[ADDR_W-1:2];
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return hit(a, OFS_CTRL) | hit(a, OFS_BAUD) | hit(a, OFS_TXDATA) | hit(a, OFS_STATUS)
			| hit(a, OFS_IRQ_STAT) | hit(a, OFS_IRQ_SET) | hit(a, OFS_IRQ_MASK);
	endfunction

	// order the frame bits in line order, bit 0 goes out first
	function automatic frame_t build_frame(input logic [7:0] data, input ctrl_t c);
		frame_t f;
		logic [7:0] d;
		logic [LEN_W-1:0] pos;
		logic par;
		int n;
		f = '0;
		d = data;
		pos = '0;
		n = c.seven_bit ? 7 : 8;
		if (c.seven_bit)
		begin
			d[7] = 1'b0;
		end
		par = (^d) ^ c.odd_parity;
		if (!c.sync_mode)
		begin
			f.bits[pos] = 1'b0;
			pos = pos + 4'h1;
		end
		for (int i = 0; i < 8; i++)
		begin
			if (i < n)
			begin
				f.bits[pos] = c.msb_first ? d[3'(n - 1 - i)] : d[3'(i)];
				pos = pos + 4'h1;
			end
		end
		if (c.parity_on)
		begin
			f.bits[pos] = par;
			pos = pos + 4'h1;
		end
		if (!c.sync_mode)
		begin
			f.bits[pos] = 1'b1;
			pos = pos + 4'h1;
			if (c.two_stop)
			begin
				f.bits[pos] = 1'b1;
				pos = pos + 4'h1;
			end
		end
		f.len = pos;
		return f;
	endfunction

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// bus slave state
	logic aw_full, next_aw_full, w_full, next_w_full;
	logic [ADDR_W-1:0] wr_addr, next_wr_addr;
	logic [31:0] wr_data, next_wr_data;
	logic [3:0] wr_strb, next_wr_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic wr_now, send;

	// register state
	ctrl_t ctrl, next_ctrl;
	logic [DIV_W-1:0] baud_div, next_baud_div;
	logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_clr, irq_sw;
	logic next_irq;

	// transmitter state
	tx_state_t state, next_state;
	logic [FRAME_W-1:0] frame, next_frame;
	logic [LEN_W-1:0] left, next_left;
	logic [DIV_W-1:0] cnt, next_cnt, div_top;
	logic frame_sync, next_frame_sync, next_txd, next_sclk, tx_done, tx_busy;
	logic [1:0] tx_status;
	frame_t f_new;

	assign wr_now = aw_full & w_full & ~bvalid;
	assign tx_busy = state == TX_SHIFT;
	assign tx_status[STAT_BUSY] = tx_busy;
	assign tx_status[STAT_EMPTY] = ~tx_busy;
	assign send = wr_now & hit(wr_addr, OFS_TXDATA) & wr_strb[0] & ~tx_busy;
	assign div_top = (baud_div == '0) ? '0 : baud_div - 1'b1;
	assign f_new = build_frame(wr_data[7:0], ctrl);

	always_comb
	begin
		next_aw_full = aw_full | (awvalid & awready);
		next_w_full = w_full | (wvalid & wready);
		next_wr_addr = (awvalid & awready) ? awaddr : wr_addr;
		next_wr_data = (wvalid & wready) ? wdata : wr_data;
		next_wr_strb = (wvalid & wready) ? wstrb : wr_strb;
		next_bvalid = bvalid & ~bready;
		next_bresp = bresp;
		if (wr_now)
		begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		next_awready = ~next_aw_full & ~next_bvalid;
		next_wready = ~next_w_full & ~next_bvalid;
		next_rvalid = rvalid & ~rready;
		next_rdata = rdata;
		next_rresp = rresp;
		if (arvalid & arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			next_rdata = '0;
			if (hit(araddr, OFS_CTRL))
				next_rdata = 32'(ctrl);
			if (hit(araddr, OFS_BAUD))
				next_rdata = 32'(baud_div);
			if (hit(araddr, OFS_STATUS))
				next_rdata = 32'(tx_status); // RULE7
			if (hit(araddr, OFS_IRQ_STAT))
				next_rdata = 32'(irq_stat); // RULE12
			if (hit(araddr, OFS_IRQ_MASK))
				next_rdata = 32'(irq_mask); // RULE9 RULE13
		end
		next_arready = ~next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");

	// registers: configuration, divisor, interrupt status and mask
	always_comb
	begin
		next_ctrl = ctrl;
		next_baud_div = baud_div;
		next_irq_mask = irq_mask;
		irq_clr = '0;
		irq_sw = '0;
		if (wr_now & wr_strb[0])
		begin
			if (hit(wr_addr, OFS_CTRL))
				next_ctrl = wr_data[CTRL_W-1:0]; // RULE1 RULE2 RULE3 RULE4 RULE5
			if (hit(wr_addr, OFS_BAUD))
				next_baud_div[7:0] = wr_data[7:0]; // RULE14
			if (hit(wr_addr, OFS_IRQ_MASK))
				next_irq_mask = wr_data[IRQ_W-1:0]; // RULE8 RULE13
			if (hit(wr_addr, OFS_IRQ_STAT))
				irq_clr = wr_data[IRQ_W-1:0]; // RULE11
			if (hit(wr_addr, OFS_IRQ_SET))
				irq_sw = wr_data[IRQ_W-1:0]; // RULE10
		end
		if (wr_now & wr_strb[1] & hit(wr_addr, OFS_BAUD))
			next_baud_div[DIV_W-1:8] = wr_data[DIV_W-1:8]; // RULE14
		// a hardware event in the clearing cycle wins over the clear
		next_irq_stat = (irq_stat & ~irq_clr) | irq_sw;
		next_irq_stat[IRQ_TX] = next_irq_stat[IRQ_TX] | tx_done;
		next_irq = |(next_irq_stat & next_irq_mask); // RULE8
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= CTRL_RESET;
			baud_div <= RESET_DIV;
			irq_stat <= IRQ_RESET;
			irq_mask <= IRQ_RESET;
			irq <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			baud_div <= next_baud_div;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			irq <= next_irq;
		end
	end

	a_irq_gated: assert property (irq == |(irq_stat & irq_mask)) // RULE8
		else $error("interrupt output disagrees with status and mask");
	a_flag_sw_set: assert property (wr_now && wr_strb[0] && hit(wr_addr, OFS_IRQ_SET)
		&& wr_data[IRQ_TX] |=> irq_stat[IRQ_TX]) // RULE10
		else $error("software set did not raise transmit flag");
	a_flag_clear: assert property (wr_now && wr_strb[0] && hit(wr_addr, OFS_IRQ_STAT)
		&& wr_data[IRQ_TX] && !tx_done |=> !irq_stat[IRQ_TX]) // RULE11
		else $error("transmit flag not cleared");
	a_done_sets_flag: assert property (tx_done |=> irq_stat[IRQ_TX]) // RULE12
		else $error("frame end did not set transmit flag");
	a_rx_enable_kept: assert property (wr_now && wr_strb[0] && hit(wr_addr, OFS_IRQ_MASK)
		|=> irq_mask[IRQ_RX] == $past(wr_data[IRQ_RX])) // RULE13
		else $error("receive enable not stored");
	a_baud_reload: assert property (wr_now && wr_strb == 4'hf && hit(wr_addr, OFS_BAUD)
		|=> baud_div == $past(wr_data[DIV_W-1:0])) // RULE14
		else $error("baud divisor not updated");

	// transmitter: one frame per accepted byte, bit time from the live divisor
	always_comb
	begin
		next_state = state;
		next_frame = frame;
		next_left = left;
		next_cnt = cnt;
		next_frame_sync = frame_sync;
		next_txd = txd;
		next_sclk = 1'b0;
		tx_done = 1'b0;
		unique case (state)
			TX_IDLE:
			begin
				next_txd = 1'b1;
				if (send)
				begin
					next_frame = f_new.bits; // RULE6
					next_left = f_new.len;
					next_cnt = div_top;
					next_frame_sync = ctrl.sync_mode; // RULE5
					next_txd = f_new.bits[0];
					next_state = TX_SHIFT;
				end
			end
			TX_SHIFT:
			begin
				if (cnt == '0)
				begin
					next_frame = frame >> 1;
					next_left = left - 4'h1;
					next_cnt = div_top;
					next_txd = frame[1];
					if (left == 4'h1)
					begin
						next_state = TX_IDLE;
						next_txd = 1'b1;
						tx_done = 1'b1;
					end
				end
				else
				begin
					next_cnt = cnt - 1'b1;
				end
				next_sclk = frame_sync & (next_state == TX_SHIFT)
					& (next_cnt < (baud_div >> 1)); // RULE5
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= TX_IDLE;
			frame <= '0;
			left <= '0;
			cnt <= '0;
			frame_sync <= 1'b0;
			txd <= 1'b1;
			sclk <= 1'b0;
		end
		else
		begin
			state <= next_state;
			frame <= next_frame;
			left <= next_left;
			cnt <= next_cnt;
			frame_sync <= next_frame_sync;
			txd <= next_txd;
			sclk <= next_sclk;
		end
	end

	a_busy_after_send: assert property (send |=> tx_busy && tx_status[STAT_BUSY]) // RULE6 RULE7
		else $error("send did not make transmitter busy");
	a_start_bit_low: assert property (send && !ctrl.sync_mode |=> !txd) // RULE5
		else $error("asynchronous frame without start bit");
	a_frame_length: assert property (send |=> left == $past(LEN_W'(
		(ctrl.sync_mode ? 0 : (ctrl.two_stop ? 3 : 2)) + (ctrl.seven_bit ? 7 : 8)
		+ (ctrl.parity_on ? 1 : 0)))) // RULE1 RULE2 RULE4
		else $error("frame length does not match configuration");
	a_msb_order: assert property (send && ctrl.msb_first && !ctrl.seven_bit
		&& !ctrl.sync_mode |=> frame[1] == $past(wr_data[7])) // RULE3
		else $error("msb first order not applied");
	a_idle_line_high: assert property (!tx_busy |-> txd && !sclk)
		else $error("line not idle while transmitter empty");

endmodule

// File: test/line_sink.sv
`timescale 1ns/10ps
module line_sink (
	// clock and serial line
	input wire logic aclk,
	input wire logic txd,
	input wire logic sclk,
	// frame setup from the bench
	input wire logic arm,
	input wire logic sync_mode,
	input wire logic [3:0] nb,
	input wire logic [15:0] baud,
	// captured bits
	output logic [15:0] got,
	output int cnt
);
	// far-side receiver: once armed, captures one frame
	initial
	begin
		got = 16'h0000;
		cnt = 0;
		forever
		begin
			@(arm);
			if (sync_mode)
				repeat (nb)
				begin
					@(posedge sclk);
					got = {got[14:0], txd};
				end
			else
			begin
				@(negedge txd);
				repeat (baud / 2) @(posedge aclk);
				got = {got[14:0], txd};
				repeat (nb - 4'h1)
				begin
					repeat (baud) @(posedge aclk);
					got = {got[14:0], txd};
				end
			end
			cnt++;
		end
	end
endmodule

// File: test/uart_frame_config_tx_status_test.sv
`timescale 1ns/10ps
module uart_frame_config_tx_status_test;
	import serial_port_a_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, arm;
	logic awready, wready, bvalid, arready, rvalid, txd, sclk, irq, m;
	logic [7:0] awaddr, araddr, d;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] cfg;
	logic [19:0] ef;
	logic [15:0] got, baud, mask;
	int bad_count, cmp_count, cyc, cnt, i;
	integer seed;
	logic [7:0] adr [6] = '{OFS_CTRL, OFS_BAUD, OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK, 8'h1c};
	logic [31:0] rv [6] = '{32'h0, 32'h4, 32'h2, 32'h0, 32'h0, 32'h0};

	serial_port_a #(.RESET_DIV(16'h0004)) i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .txd, .sclk, .irq);
	line_sink i_sink (.aclk, .txd, .sclk, .arm, .sync_mode(cfg[5]), .nb(ef[19:16]), .baud,
		.got, .cnt);

	initial
	begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			summarize();
		end
	end

	task summarize();
		if (bad_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one axi4-lite write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		tb = 1'h0;
		while (!tb)
		begin
			@(posedge aclk);
			if (awvalid & awready) awvalid <= 1'h0;
			if (wvalid & wready) wvalid <= 1'h0;
			tb = bvalid & bready;
			resp = bresp;
			if (tb) bready <= 1'h0;
		end
	endtask

	task rdr(input logic [7:0] a);
		logic tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		tr = 1'h0;
		while (!tr)
		begin
			@(posedge aclk);
			if (arvalid & arready) arvalid <= 1'h0;
			tr = rvalid & rready;
			rd = rdata;
			resp = rresp;
			if (tr) rready <= 1'h0;
		end
	endtask

	// expected line bits, first bit highest; bit count on top
	function automatic logic [19:0] frame(input logic [5:0] c, input logic [7:0] v);
		logic [15:0] f;
		logic p;
		int k, n, s;
		f = 16'h0000;
		p = c[4];
		k = c[5] ? 0 : 1;
		n = c[1] ? 7 : 8;
		for (int j = 0; j < n; j++)
		begin
			f = {f[14:0], c[2] ? v[n - 1 - j] : v[j]};
			p ^= f[0];
			k++;
		end
		f = c[3] ? {f[14:0], p} : f;
		k += c[3];
		s = c[5] ? 0 : 1 + c[0];
		f = (f << s) | 16'((1 << s) - 1);
		return {4'(k + s), f};
	endfunction

	initial
	begin
		seed = 32'h1db7;
		aresetn = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready, arm} = 6'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		cfg = 6'h00;
		ef = 20'h0;
		baud = 16'h0004;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		for (i = 0; i < 6; i++)
		begin
			rdr(adr[i]);
			chk("reset value", rd, rv[i]);
		end
		chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
		wr(OFS_IRQ_SET, 32'h1);
		rdr(OFS_IRQ_STAT);
		chk("soft set", rd, 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'h3);
		rdr(OFS_IRQ_MASK);
		chk("mask", rd, 32'h3);
		chk("irq on", 32'(irq), 32'h1);
		wr(OFS_IRQ_STAT, 32'h1);
		rdr(OFS_IRQ_STAT);
		chk("clear", rd, 32'h0);
		chk("irq off", 32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'h2);
		rdr(OFS_IRQ_MASK);
		chk("rx enable", rd, 32'h2);
		for (int n = 0; n < 12; n++)
		begin
			cfg = n == 0 ? 6'h1f : n == 1 ? 6'h2e : 6'($random(seed));
			d = n == 2 ? 8'hff : 8'($random(seed));
			m = 1'($random(seed));
			baud = n == 11 ? 16'h0006 : 16'h0004;
			wr(OFS_BAUD, 32'(baud));
			wr(OFS_CTRL, 32'(cfg));
			wr(OFS_IRQ_MASK, 32'(m));
			ef = frame(cfg, d);
			mask = ~(16'hffff << ef[19:16]);
			i = cnt;
			arm <= ~arm;
			wr(OFS_TXDATA, 32'(d));
			wr(OFS_TXDATA, 32'(~d));
			chk("drop resp", 32'(resp), 32'(RESP_OKAY));
			rdr(OFS_STATUS);
			chk("busy", rd, 32'h1);
			while (rd !== 32'h2) rdr(OFS_STATUS);
			chk("frame", 32'(got & mask), 32'(ef[15:0]));
			chk("frames", cnt - i, 32'h1);
			chk("irq", 32'(irq), 32'(m));
			rdr(OFS_IRQ_STAT);
			chk("pending", rd, 32'h1);
			wr(OFS_IRQ_STAT, 32'h1);
			rdr(OFS_STATUS);
			chk("dropped", rd, 32'h2);
		end
		summarize();
	end
endmodule
